// File: src/cssw_defs.svh
`ifndef CSSW_DEFS_SVH
`define CSSW_DEFS_SVH

// ==========================================================================
// Register map
// ==========================================================================
`define CSSW_ADDR_W          2
`define CSSW_DATA_W          8
`define CSSW_OFS_SELECT      2'h0
`define CSSW_OFS_SYNTH_CTL   2'h1
`define CSSW_OFS_STATUS      2'h2

// ==========================================================================
// Clock source select register fields
// ==========================================================================
`define CSSW_BIT_SYNTH_SEL   7
`define CSSW_BIT_PSEUDO      6
`define CSSW_BIT_SYS_WAI     5
`define CSSW_BIT_ROA_WAI     4
`define CSSW_BIT_SYNTH_WAI   3
`define CSSW_BIT_CORE_WAI    2
`define CSSW_BIT_PIT_WAI     1
`define CSSW_BIT_WDOG_WAI    0
`define CSSW_RST_SELECT      8'h00
`define CSSW_RST_SYNTH_SEL   1'h0

// ==========================================================================
// Synthesizer control register fields
// ==========================================================================
`define CSSW_BIT_POWER_ON    6
`define CSSW_BIT_AUTO_BW     5
`define CSSW_BIT_ACQ         4
`define CSSW_RST_POWER_ON    1'h1
`define CSSW_RST_AUTO_BW     1'h1
`define CSSW_RST_ACQ         1'h1

// ==========================================================================
// Status register fields
// ==========================================================================
`define CSSW_BIT_LOCK        3
`define CSSW_BIT_TRACK       2
`define CSSW_BIT_SCM         0

// ==========================================================================
// Bus clock divider
// ==========================================================================
`define CSSW_BUS_DIV_LAST    1'h1

`endif

// File: src/cssw_pkg.sv
package cssw_pkg;

  typedef enum logic [1:0]
  {
    CSSW_RUN  = 2'b00,
    CSSW_WAIT = 2'b01,
    CSSW_STOP = 2'b10
  } cssw_mode_t;

  typedef struct packed
  {
    cssw_mode_t  mode;
    logic        synth_sel;
    logic        pseudo_halt_enable;
    logic        system_clocks_halt_in_wait;
    logic        reduced_amplitude_in_wait;
    logic        synth_halt_in_wait;
    logic        core_clock_halt_in_wait;
    logic        interrupt_timer_halt_in_wait;
    logic        watchdog_halt_in_wait;
    logic        watchdog_bit_written;
    logic        synth_power_on;
    logic        auto_bw;
    logic        acq;
    logic        scm_prev;
    logic        sys_clk_en;
    logic        core_clk_en;
    logic        osc_en;
    logic        osc_reduced;
    logic        synth_powered;
    logic        pit_run;
    logic        pit_clear;
    logic        wdog_run;
    logic        wdog_clear;
    logic        bus_clk_en;
    logic [7:0]  rd_data;
  } cssw_state_t;

endpackage

// File: src/cssw_bus_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "cssw_defs.svh"

// ==========================================================================
// Bus clock enable: one pulse for every second tick of the chosen source.
// ==========================================================================
module cssw_bus_divider
(
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic osc_tick_in,
  input  wire logic synth_tick_in,
  input  wire logic synth_sel_in,
  output var  logic bus_en_out
);

  logic       phase;
  logic       sel_prev;
  logic       tick;

  assign tick = synth_sel_in ? synth_tick_in : osc_tick_in;

  // A source change restarts the divide so no short bus period leaks out.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      phase      <= 1'b0;
      sel_prev   <= 1'b0;
      bus_en_out <= 1'b0;
    end
    else
    begin
      sel_prev   <= synth_sel_in;
      bus_en_out <= 1'b0;
      if (sel_prev != synth_sel_in)
      begin
        phase <= 1'b0;
      end
      else if (tick)
      begin
        phase      <= ~phase;
        bus_en_out <= (phase == `CSSW_BUS_DIV_LAST);
      end
    end
  end

endmodule // cssw_bus_divider

`default_nettype wire

// File: src/cssw_clock_select.sv
// Overview of operation
// - Setting loop select is ignored while the loop is not lock/track stable.
// - Loop select clears on self-clock, stop, or wait entry with loop halt.
// - Select zero: system clocks from oscillator, bus clock is half of it.
// - Select one: system clocks from loop clock, bus clock is half of it.
// - Pseudo-halt bit keeps oscillator running in stop mode, reduced when supported.
// - System clocks halt in wait only when their halt bit is set.
// - System clock halt bit never touches interrupt timer or watchdog.
// - Reduced amplitude in wait when that bit is set and supported.
// - Loop halt in wait clears select and, outside self-clock, powers loop down in the same cycle.
// - Loop power-on bit still reads set while loop is down in wait.
// - Loop halt in wait bit forces automatic bandwidth to one.
// - Core clock stops in wait when its halt bit is set.
// - Interrupt timer halts and clears dividers on wait entry when set.
// - Watchdog halts and clears dividers on wait entry when set.
// - Watchdog halt bit is write-once in normal modes, free in special.
// - Lock status reflects loop tolerance and reads zero in self-clock.
// - Track status shows tracking mode and reads zero in self-clock.
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cssw_defs.svh"

module cssw_clock_select
(
  input  wire logic                         clk_in,
  input  wire logic                         arst_n_in,
  input  wire logic [`CSSW_ADDR_W-1:0]      addr_in,
  input  wire logic [`CSSW_DATA_W-1:0]      wr_data_in,
  input  wire logic                         wr_in,
  input  wire logic                         rd_in,
  input  wire logic                         lock_in,
  input  wire logic                         track_in,
  input  wire logic                         self_clock_mode_in,
  input  wire logic                         wait_mode_in,
  input  wire logic                         stop_mode_in,
  input  wire logic                         special_mode_in,
  input  wire logic                         osc_has_reduced_amp_in,
  input  wire logic                         osc_tick_in,
  input  wire logic                         synth_tick_in,
  output var  logic [`CSSW_DATA_W-1:0]      rd_data_out,
  output var  logic                         synth_clock_select_out,
  output var  logic                         bus_clock_en_out,
  output var  logic                         system_clocks_en_out,
  output var  logic                         core_clock_en_out,
  output var  logic                         osc_enable_out,
  output var  logic                         osc_reduced_amp_out,
  output var  logic                         synth_powered_out,
  output var  logic                         synth_auto_bw_out,
  output var  logic                         pit_run_out,
  output var  logic                         pit_clear_out,
  output var  logic                         wdog_run_out,
  output var  logic                         wdog_clear_out
);

  import cssw_pkg::*;

  // ========================================================================
  // State and helper signals
  // ========================================================================
  cssw_state_t st;
  cssw_state_t next_st;
  cssw_mode_t  next_mode;
  logic        div_bus_en;
  logic        scm_entry;
  logic        wait_entry;
  logic        stop_entry;
  logic        in_wait;
  logic        in_stop;
  logic        auto_eff;
  logic        lock_vis;
  logic        track_vis;
  logic        sel_allowed;
  logic        wr_select;
  logic        wr_synth;

  // ========================================================================
  // Bus clock divider
  // ========================================================================
  cssw_bus_divider u_bus_div
  (
    .clk_in        (clk_in),
    .arst_n_in     (arst_n_in),
    .osc_tick_in   (osc_tick_in),
    .synth_tick_in (synth_tick_in),
    .synth_sel_in  (st.synth_sel),
    .bus_en_out    (div_bus_en)
  );

  // ========================================================================
  // Next state
  // ========================================================================
  always_comb
  begin
    next_st           = st;
    next_st.pit_clear = 1'b0;
    next_st.wdog_clear = 1'b0;

    // Stop has priority over wait when both are requested.
    if (stop_mode_in)
    begin
      next_mode = CSSW_STOP;
    end
    else if (wait_mode_in)
    begin
      next_mode = CSSW_WAIT;
    end
    else
    begin
      next_mode = CSSW_RUN;
    end
    next_st.mode = next_mode;

    in_wait    = (next_mode == CSSW_WAIT);
    in_stop    = (next_mode == CSSW_STOP);
    wait_entry = in_wait && (st.mode != CSSW_WAIT);
    stop_entry = in_stop && (st.mode != CSSW_STOP);
    scm_entry  = self_clock_mode_in && !st.scm_prev;
    next_st.scm_prev = self_clock_mode_in;

    lock_vis  = lock_in && !self_clock_mode_in;
    track_vis = track_in && !self_clock_mode_in;
    auto_eff  = st.auto_bw || st.synth_halt_in_wait;
    sel_allowed = auto_eff ? lock_vis : track_vis;

    wr_select = wr_in && (addr_in == `CSSW_OFS_SELECT);
    wr_synth  = wr_in && (addr_in == `CSSW_OFS_SYNTH_CTL);

    // ----------------------------------------------------------------------
    // Register writes.
    // ----------------------------------------------------------------------
    if (wr_select)
    begin
      if (!wr_data_in[`CSSW_BIT_SYNTH_SEL])
      begin
        next_st.synth_sel = 1'b0;
      end
      else if (sel_allowed)
      begin
        next_st.synth_sel = 1'b1;
      end
      next_st.pseudo_halt_enable =
        wr_data_in[`CSSW_BIT_PSEUDO];
      next_st.system_clocks_halt_in_wait =
        wr_data_in[`CSSW_BIT_SYS_WAI];
      next_st.reduced_amplitude_in_wait =
        wr_data_in[`CSSW_BIT_ROA_WAI];
      next_st.synth_halt_in_wait =
        wr_data_in[`CSSW_BIT_SYNTH_WAI];
      next_st.core_clock_halt_in_wait =
        wr_data_in[`CSSW_BIT_CORE_WAI];
      next_st.interrupt_timer_halt_in_wait =
        wr_data_in[`CSSW_BIT_PIT_WAI];
      if (special_mode_in || !st.watchdog_bit_written)
      begin
        next_st.watchdog_halt_in_wait =
          wr_data_in[`CSSW_BIT_WDOG_WAI];
        next_st.watchdog_bit_written = 1'b1;
      end
    end

    if (wr_synth)
    begin
      next_st.synth_power_on = wr_data_in[`CSSW_BIT_POWER_ON];
      next_st.auto_bw        = wr_data_in[`CSSW_BIT_AUTO_BW];
      next_st.acq            = wr_data_in[`CSSW_BIT_ACQ];
    end

    // The forced bandwidth bit overrides any software write.
    if (next_st.synth_halt_in_wait)
    begin
      next_st.auto_bw = 1'b1;
    end

    // ----------------------------------------------------------------------
    // Hardware clear of the loop select wins over a software set.
    // ----------------------------------------------------------------------
    if (scm_entry || stop_entry)
    begin
      next_st.synth_sel = 1'b0;
    end
    if (wait_entry && next_st.synth_halt_in_wait)
    begin
      next_st.synth_sel = 1'b0;
    end

    // ----------------------------------------------------------------------
    // Low-power controls.
    // ----------------------------------------------------------------------
    next_st.sys_clk_en =
      !in_stop && !(in_wait && next_st.system_clocks_halt_in_wait);
    next_st.core_clk_en =
      !in_stop && !(in_wait && next_st.core_clock_halt_in_wait);
    next_st.osc_en = !in_stop || next_st.pseudo_halt_enable;
    next_st.osc_reduced = osc_has_reduced_amp_in &&
      ((in_stop && next_st.pseudo_halt_enable) ||
       (in_wait && next_st.reduced_amplitude_in_wait));
    next_st.synth_powered = self_clock_mode_in ||
      (next_st.synth_power_on && !in_stop &&
       !(in_wait && next_st.synth_halt_in_wait));

    // Timer and watchdog follow only their own wait bits.
    next_st.pit_run =
      !(in_wait && next_st.interrupt_timer_halt_in_wait);
    next_st.pit_clear =
      wait_entry && next_st.interrupt_timer_halt_in_wait;
    next_st.wdog_run =
      !(in_wait && next_st.watchdog_halt_in_wait);
    next_st.wdog_clear =
      wait_entry && next_st.watchdog_halt_in_wait;

    next_st.bus_clk_en = div_bus_en && st.sys_clk_en;

    // ----------------------------------------------------------------------
    // Read data stands for one cycle after the read strobe.
    // ----------------------------------------------------------------------
    next_st.rd_data = '0;
    if (rd_in)
    begin
      case (addr_in)
        `CSSW_OFS_SELECT:
        begin
          next_st.rd_data[`CSSW_BIT_SYNTH_SEL] = st.synth_sel;
          next_st.rd_data[`CSSW_BIT_PSEUDO]    = st.pseudo_halt_enable;
          next_st.rd_data[`CSSW_BIT_SYS_WAI]   =
            st.system_clocks_halt_in_wait;
          next_st.rd_data[`CSSW_BIT_ROA_WAI]   =
            st.reduced_amplitude_in_wait;
          next_st.rd_data[`CSSW_BIT_SYNTH_WAI] = st.synth_halt_in_wait;
          next_st.rd_data[`CSSW_BIT_CORE_WAI]  = st.core_clock_halt_in_wait;
          next_st.rd_data[`CSSW_BIT_PIT_WAI]   =
            st.interrupt_timer_halt_in_wait;
          next_st.rd_data[`CSSW_BIT_WDOG_WAI]  = st.watchdog_halt_in_wait;
        end
        `CSSW_OFS_SYNTH_CTL:
        begin
          next_st.rd_data[`CSSW_BIT_POWER_ON]  = st.synth_power_on;
          next_st.rd_data[`CSSW_BIT_AUTO_BW]   = st.auto_bw;
          next_st.rd_data[`CSSW_BIT_ACQ]       = st.acq;
        end
        `CSSW_OFS_STATUS:
        begin
          next_st.rd_data[`CSSW_BIT_LOCK]  = lock_vis;
          next_st.rd_data[`CSSW_BIT_TRACK] = track_vis;
          next_st.rd_data[`CSSW_BIT_SCM]   = self_clock_mode_in;
        end
        default:
        begin
          next_st.rd_data = '0;
        end
      endcase
    end
  end

  // ========================================================================
  // State register
  // ========================================================================
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st                              <= '0;
      st.mode                         <= CSSW_RUN;
      st.synth_sel                    <= `CSSW_RST_SYNTH_SEL;
      st.synth_power_on               <= `CSSW_RST_POWER_ON;
      st.auto_bw                      <= `CSSW_RST_AUTO_BW;
      st.acq                          <= `CSSW_RST_ACQ;
      st.sys_clk_en                   <= 1'b1;
      st.core_clk_en                  <= 1'b1;
      st.osc_en                       <= 1'b1;
      st.synth_powered                <= `CSSW_RST_POWER_ON;
      st.pit_run                      <= 1'b1;
      st.wdog_run                     <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  assign rd_data_out            = st.rd_data;
  assign synth_clock_select_out = st.synth_sel;
  assign bus_clock_en_out       = st.bus_clk_en;
  assign system_clocks_en_out   = st.sys_clk_en;
  assign core_clock_en_out      = st.core_clk_en;
  assign osc_enable_out         = st.osc_en;
  assign osc_reduced_amp_out    = st.osc_reduced;
  assign synth_powered_out      = st.synth_powered;
  assign synth_auto_bw_out      = st.auto_bw;
  assign pit_run_out            = st.pit_run;
  assign pit_clear_out          = st.pit_clear;
  assign wdog_run_out           = st.wdog_run;
  assign wdog_clear_out         = st.wdog_clear;

endmodule // cssw_clock_select

`default_nettype wire

// File: dv/cssw_clock_select_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "cssw_defs.svh"

// ==========================================================================
// Port checker for the clock select block
// ==========================================================================
module cssw_clock_select_assertions
(
  input wire logic                    clk_in,
  input wire logic                    arst_n_in,
  input wire logic [`CSSW_ADDR_W-1:0] addr_in,
  input wire logic [`CSSW_DATA_W-1:0] wr_data_in,
  input wire logic                    wr_in,
  input wire logic                    rd_in,
  input wire logic                    lock_in,
  input wire logic                    track_in,
  input wire logic                    self_clock_mode_in,
  input wire logic                    wait_mode_in,
  input wire logic                    stop_mode_in,
  input wire logic                    special_mode_in,
  input wire logic                    osc_has_reduced_amp_in,
  input wire logic                    osc_tick_in,
  input wire logic                    synth_tick_in,
  input wire logic [`CSSW_DATA_W-1:0] rd_data_out,
  input wire logic                    synth_clock_select_out,
  input wire logic                    bus_clock_en_out,
  input wire logic                    system_clocks_en_out,
  input wire logic                    core_clock_en_out,
  input wire logic                    osc_enable_out,
  input wire logic                    osc_reduced_amp_out,
  input wire logic                    synth_powered_out,
  input wire logic                    synth_auto_bw_out,
  input wire logic                    pit_run_out,
  input wire logic                    pit_clear_out,
  input wire logic                    wdog_run_out,
  input wire logic                    wdog_clear_out
);
  logic [7:0] shadow;
  logic       stable;
  logic       sel_wr;

  // Mirror of the select register, rebuilt from bus writes.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      shadow <= 8'h00;
    else if (sel_wr)
      shadow <= wr_data_in;
  end

  assign sel_wr = wr_in && (addr_in == `CSSW_OFS_SELECT);
  assign stable = !self_clock_mode_in
                  && (synth_auto_bw_out ? lock_in : track_in);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence s_in_wait;
    wait_mode_in && !stop_mode_in && !self_clock_mode_in;
  endsequence
  sequence s_wait_held;
    s_in_wait ##1 s_in_wait ##1 s_in_wait;
  endsequence
  sequence s_wait_entry;
    $rose(wait_mode_in) && !stop_mode_in && !self_clock_mode_in;
  endsequence

  property p_sel_refused;
    sel_wr && wr_data_in[7] && !stable && !synth_clock_select_out
      |=> !synth_clock_select_out;
  endproperty
  a_sel_refused: assert property (p_sel_refused)
    else $error("loop select taken while loop unstable");
  property p_sel_taken;
    sel_wr && wr_data_in[7] && stable && !wait_mode_in && !stop_mode_in
      |=> synth_clock_select_out;
  endproperty
  a_sel_taken: assert property (p_sel_taken)
    else $error("loop select refused while loop stable");
  property p_clear_stop;
    $rose(stop_mode_in) |=> !synth_clock_select_out;
  endproperty
  a_clear_stop: assert property (p_clear_stop)
    else $error("loop select kept on stop entry");
  property p_clear_scm;
    $rose(self_clock_mode_in) |=> !synth_clock_select_out;
  endproperty
  a_clear_scm: assert property (p_clear_scm)
    else $error("loop select kept on self-clock entry");
  property p_wait_synth;
    s_wait_entry ##0 shadow[3] |=> !synth_clock_select_out
      && !synth_powered_out;
  endproperty
  a_wait_synth: assert property (p_wait_synth)
    else $error("loop not released on wait entry");
  property p_auto_forced;
    shadow[3] && $past(shadow[3]) |-> synth_auto_bw_out;
  endproperty
  a_auto_forced: assert property (p_auto_forced)
    else $error("automatic bandwidth not forced");
  property p_sys_wait;
    s_wait_held |-> system_clocks_en_out == !shadow[5];
  endproperty
  a_sys_wait: assert property (p_sys_wait)
    else $error("system clocks wrong in wait");
  property p_core_wait;
    s_wait_held |-> core_clock_en_out == !shadow[2];
  endproperty
  a_core_wait: assert property (p_core_wait)
    else $error("core clock wrong in wait");
  property p_pit_entry;
    s_wait_entry |=> pit_clear_out == shadow[1];
  endproperty
  a_pit_entry: assert property (p_pit_entry)
    else $error("timer clear pulse wrong on wait entry");
  property p_stop_osc;
    (stop_mode_in && !self_clock_mode_in) [*3]
      |-> osc_enable_out == shadow[6];
  endproperty
  a_stop_osc: assert property (p_stop_osc)
    else $error("oscillator enable wrong in stop");
  property p_bus_gap;
    bus_clock_en_out |=> !bus_clock_en_out;
  endproperty
  a_bus_gap: assert property (p_bus_gap)
    else $error("bus clock pulses back to back");
endmodule // cssw_clock_select_assertions

bind cssw_clock_select cssw_clock_select_assertions u_chk (.*);

`default_nettype wire

// File: dv/cssw_clock_select_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "cssw_defs.svh"

// ==========================================================================
// Self-checking bench of the clock select block
// ==========================================================================
module cssw_clock_select_bench;
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic [1:0]  addr_in = 2'h0;
  logic [7:0]  wr_data_in = 8'h00;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        lock_in = 1'b0;
  logic        track_in = 1'b0;
  logic        sc_in = 1'b0;
  logic        wait_in = 1'b0;
  logic        stop_in = 1'b0;
  logic        spec_in = 1'b0;
  logic        has_in = 1'b0;
  logic        osc_tick_in = 1'b0;
  logic        synth_tick_in = 1'b0;
  logic [7:0]  rd_data_out;
  logic        sel_o, bus_o, sys_o, core_o, osc_o, roa_o;
  logic        pwr_o, auto_o, pitr_o, pitc_o, wdr_o, wdc_o;
  logic [31:0] seed = 32'hFC10;
  logic [31:0] tseed = 32'hFC10;
  logic [7:0]  d;
  logic        e;
  logic        sc;
  int          nt;
  int          nbus;
  int          mismatches = 0;
  int          checked = 0;

  cssw_clock_select u_dut
  (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .lock_in(lock_in), .track_in(track_in), .self_clock_mode_in(sc_in),
    .wait_mode_in(wait_in), .stop_mode_in(stop_in),
    .special_mode_in(spec_in), .osc_has_reduced_amp_in(has_in),
    .osc_tick_in(osc_tick_in), .synth_tick_in(synth_tick_in),
    .rd_data_out(rd_data_out), .synth_clock_select_out(sel_o),
    .bus_clock_en_out(bus_o), .system_clocks_en_out(sys_o),
    .core_clock_en_out(core_o), .osc_enable_out(osc_o),
    .osc_reduced_amp_out(roa_o), .synth_powered_out(pwr_o),
    .synth_auto_bw_out(auto_o), .pit_run_out(pitr_o),
    .pit_clear_out(pitc_o), .wdog_run_out(wdr_o), .wdog_clear_out(wdc_o)
  );

  // ==========================================================================
  // Clock, random source ticks and helpers
  // ==========================================================================
  initial
  begin
    forever #5 clk_in = ~clk_in;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  always @(posedge clk_in)
  begin
    tseed <= xs(tseed);
    osc_tick_in <= tseed[0];
    synth_tick_in <= tseed[1];
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] m,
                    input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk8(rd_data_out & m, exp);
  endtask

  task automatic complete_run;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #100000;
    mismatches++;
    complete_run();
  end

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial
  begin
    repeat (10) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rd(2'h0, 8'hFF, 8'h00);
    rd(2'h1, 8'h70, 8'h70);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'hFF, 8'h00);
    wr(2'h0, 8'h01);
    rd(2'h0, 8'hFF, 8'h01);
    wr(2'h0, 8'h00);
    rd(2'h0, 8'hFF, 8'h01);
    $display("test reset_and_write_once done");
    for (int i = 0; i < 16; i++)
    begin
      seed = xs(seed);
      d = {1'b0, seed[6:1], 1'b0};
      sc = seed[12] & seed[13];
      wr(2'h0, d);
      wr(2'h1, {2'b01, seed[11], 5'h00});
      lock_in <= seed[8];
      track_in <= seed[9];
      sc_in <= sc;
      wr(2'h0, d | 8'h80);
      e = !sc && ((seed[11] | d[3]) ? seed[8] : seed[9]);
      #1 chk1(sel_o, e);
      chk1(auto_o, seed[11] | d[3]);
      rd(2'h0, 8'hFE, {e, d[6:1], 1'b0});
      rd(2'h1, 8'h20, {2'b00, seed[11] | d[3], 5'h00});
      rd(2'h2, 8'h0D,
         {4'h0, !sc & seed[8], !sc & seed[9], 1'b0, sc});
      sc_in <= 1'b0;
    end
    $display("test select_gating done");
    wr(2'h1, 8'h60);
    lock_in <= 1'b1;
    track_in <= 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      seed = xs(seed);
      has_in <= seed[0];
      wr(2'h0, {1'b1, p[0], 6'h00});
      stop_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      #1 chk1(sel_o, 1'b0);
      chk1(osc_o, p[0]);
      chk1(roa_o, p[0] & seed[0]);
      stop_in <= 1'b0;
    end
    $display("test stop_mode done");
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      d = {2'b10, seed[5:4], i[0], seed[2:1], 1'b0};
      has_in <= seed[9];
      wr(2'h0, d);
      wait_in <= 1'b1;
      @(posedge clk_in);
      #1 chk1(pitc_o, d[1]);
      chk1(wdc_o, 1'b1);
      repeat (2) @(posedge clk_in);
      #1 chk1(sel_o, !d[3]);
      chk1(pwr_o, !d[3]);
      chk1(sys_o, !d[5]);
      chk1(core_o, !d[2]);
      chk1(roa_o, d[4] & seed[9]);
      chk1(pitr_o, !d[1]);
      chk1(wdr_o, 1'b0);
      rd(2'h1, 8'h40, 8'h40);
      wait_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1 chk1(sel_o, !d[3]);
      wr(2'h0, d);
      #1 chk1(sel_o, 1'b1);
    end
    $display("test wait_mode done");
    for (int s = 0; s < 2; s++)
    begin
      wr(2'h0, {s[0], 7'h00});
      nt = 0;
      nbus = 0;
      repeat (64)
      begin
        @(posedge clk_in);
        nt += (s == 1) ? synth_tick_in : osc_tick_in;
        nbus += bus_o;
      end
      chk1((2 * nbus <= nt + 2) && (2 * nbus + 4 >= nt), 1'b1);
    end
    $display("test bus_divide done");
    spec_in <= 1'b1;
    wr(2'h0, 8'h00);
    rd(2'h0, 8'h01, 8'h00);
    wr(2'h0, 8'h01);
    rd(2'h0, 8'h01, 8'h01);
    $display("test special_mode done");
    complete_run();
  end
endmodule // cssw_clock_select_bench

`default_nettype wire
